// [core/sld_line_regs.vh]
`ifndef SLD_LINE_REGS_VH
`define SLD_LINE_REGS_VH

// Driver settings.
`define SLD_DRV_P2P       2'h0
`define SLD_DRV_HALF      2'h1
`define SLD_DRV_TWO_WIRE  2'h2

// Port protocol codes.
`define SLD_PROTO_OTHER   2'h0
`define SLD_PROTO_RN_MST  2'h1
`define SLD_PROTO_RN_SLV  2'h2

// Port numbers offering selectable driver settings.
`define SLD_PORT_SEL_A    2'h1
`define SLD_PORT_SEL_B    2'h2

// Options register bits set by the two-wire setting.
`define SLD_OPT_BIT_LO    7
`define SLD_OPT_BIT_HI    8

// CTS delay tick unit, in microseconds, and clock period in nanoseconds.
`define SLD_TICK_US       10000
`define SLD_CLK_NS        8

// Handshake states.
`define SLD_ST_IDLE       2'h0
`define SLD_ST_DELAY      2'h1
`define SLD_ST_WAITCTS    2'h2
`define SLD_ST_SEND       2'h3

`endif

// [core/sld_line_driver.v]
// Contract
// - Selectable driver settings apply only on ports 1 and 2 in network protocol.
// - Point-to-point is default and the only setting elsewhere.
// - Point-to-point keeps transmit drivers always enabled, full duplex.
// - Half duplex keeps drivers enabled, receiver off while transmitting.
// - Two-wire: driver tri-stated at rest, enabled only by clear-to-send state.
// - Two-wire: receiver disabled whenever the driver is enabled.
// - Two-wire setting sets options register bits 7 and 8.
// - Request-to-send asserts as soon as data is queued.
// - Send starts only after CTS delay elapsed and clear-to-send present.
// - Zero CTS delay skips the delay and waits only for clear-to-send.
// - Missing clear-to-send raises no error; waiting continues indefinitely.
// - CTS delay counts in 10 millisecond units.
`timescale 1ns/1ps
`default_nettype none
`include "sld_line_regs.vh"

module sld_line_driver #(
    parameter DELAY_W  = 16,
    parameter OPT_W    = 16,
    parameter TICK_CYC = ((`SLD_TICK_US * 1000) + `SLD_CLK_NS - 1) / `SLD_CLK_NS
) (
    // Clock and reset
    input  wire               clk,
    input  wire               rst,
    // Configuration
    input  wire [1:0]         portNum,
    input  wire [1:0]         protoMode,
    input  wire [1:0]         driverSel,
    input  wire [DELAY_W-1:0] ctsDelay,
    input  wire [OPT_W-1:0]   optionsIn,
    // Transmit path from the UART
    input  wire               txPending,
    input  wire               txLastDone,
    // Line inputs
    input  wire               ctsIn,
    // Line outputs
    output reg                rtsOut,
    output reg                txDrvEn,
    output reg                rxEn,
    output reg                txGo,
    output reg  [1:0]         activeSetting,
    output reg  [OPT_W-1:0]   optionsOut
);

    localparam [31:0] TICK_LAST = TICK_CYC - 1;

    reg [1:0]         state_r;
    reg [1:0]         state_nxt;
    reg [1:0]         setting_r;
    reg [31:0]        tickCnt_r;
    reg [DELAY_W-1:0] unitCnt_r;
    reg               selAllowed;
    reg [1:0]         reqSetting;
    reg               rtsOut_nxt;
    reg               txDrvEn_nxt;
    reg               rxEn_nxt;
    reg               txGo_nxt;
    reg [OPT_W-1:0]   optionsOut_nxt;
    wire              tickDone;

    // The selectable settings exist only on the two multidrop ports in network mode.
    always @* begin
        selAllowed = ((portNum == `SLD_PORT_SEL_A) || (portNum == `SLD_PORT_SEL_B)) &&
                     ((protoMode == `SLD_PROTO_RN_MST) || (protoMode == `SLD_PROTO_RN_SLV));
        if (selAllowed && (driverSel == `SLD_DRV_HALF || driverSel == `SLD_DRV_TWO_WIRE)) begin
            reqSetting = driverSel;
        end else begin
            reqSetting = `SLD_DRV_P2P;
        end
    end

    assign tickDone     = (tickCnt_r == TICK_LAST);

    // No timeout exists in the wait for clear-to-send; a dead partner stalls the port.
    always @* begin
        state_nxt = state_r;
        case (state_r)
            `SLD_ST_IDLE: begin
                if (txPending) begin
                    if (ctsDelay == {DELAY_W{1'b0}}) begin
                        state_nxt = `SLD_ST_WAITCTS;
                    end else begin
                        state_nxt = `SLD_ST_DELAY;
                    end
                end
            end
            `SLD_ST_DELAY: begin
                if (tickDone && (unitCnt_r == ctsDelay - 1'b1)) begin
                    state_nxt = ctsIn ? `SLD_ST_SEND : `SLD_ST_WAITCTS;
                end
            end
            `SLD_ST_WAITCTS: begin
                if (ctsIn) begin
                    state_nxt = `SLD_ST_SEND;
                end
            end
            `SLD_ST_SEND: begin
                if (txLastDone) begin
                    state_nxt = `SLD_ST_IDLE;
                end
            end
            default: state_nxt = `SLD_ST_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            state_r <= `SLD_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // A new setting is latched only between messages, so a frame never sees its line mode flip.
    always @(posedge clk) begin
        if (rst) begin
            setting_r <= `SLD_DRV_P2P;
        end else if (state_r == `SLD_ST_IDLE && !txPending) begin
            setting_r <= reqSetting;
        end
    end

    // Delay counted in whole ticks of ten milliseconds.
    always @(posedge clk) begin
        if (rst) begin
            tickCnt_r <= 32'h0;
        end else if (state_r == `SLD_ST_DELAY && !tickDone) begin
            tickCnt_r <= tickCnt_r + 32'h1;
        end else begin
            tickCnt_r <= 32'h0;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            unitCnt_r <= {DELAY_W{1'b0}};
        end else if (state_r != `SLD_ST_DELAY) begin
            unitCnt_r <= {DELAY_W{1'b0}};
        end else if (tickDone) begin
            unitCnt_r <= unitCnt_r + 1'b1;
        end
    end

    // Line controls are derived from the next state so the registered pins line up with it.
    always @* begin
        rtsOut_nxt     = (state_nxt != `SLD_ST_IDLE);
        txGo_nxt       = (state_nxt == `SLD_ST_SEND);
        optionsOut_nxt = optionsIn;
        txDrvEn_nxt    = 1'b1;
        rxEn_nxt       = 1'b1;
        case (setting_r)
            `SLD_DRV_HALF: begin
                txDrvEn_nxt = 1'b1;
                rxEn_nxt    = !(state_nxt == `SLD_ST_SEND);
            end
            `SLD_DRV_TWO_WIRE: begin
                // The driver follows the partner even between messages; it owns the pair then.
                txDrvEn_nxt = ctsIn;
                rxEn_nxt    = !ctsIn;
                optionsOut_nxt[`SLD_OPT_BIT_LO] = 1'b1;
                optionsOut_nxt[`SLD_OPT_BIT_HI] = 1'b1;
            end
            default: begin
                txDrvEn_nxt = 1'b1;
                rxEn_nxt    = 1'b1;
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            rtsOut <= 1'b0;
        end else begin
            rtsOut <= rtsOut_nxt;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            txGo <= 1'b0;
        end else begin
            txGo <= txGo_nxt;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            txDrvEn <= 1'b1;
        end else begin
            txDrvEn <= txDrvEn_nxt;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            rxEn <= 1'b1;
        end else begin
            rxEn <= rxEn_nxt;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            activeSetting <= `SLD_DRV_P2P;
        end else begin
            activeSetting <= setting_r;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            optionsOut <= {OPT_W{1'b0}};
        end else begin
            optionsOut <= optionsOut_nxt;
        end
    end

endmodule
`default_nettype wire

// [tb/sld_line_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module sld_line_asserts #(parameter TICK_CYC = 1250000) (
    // Clock, reset and handshake
    input wire logic        clk, rst, txPending, txLastDone, ctsIn,
    input wire logic        rtsOut, txDrvEn, rxEn, txGo,
    // Configuration and status
    input wire logic [1:0]  portNum, protoMode, activeSetting,
    input wire logic [15:0] ctsDelay, optionsOut
);
    logic [31:0] cnt_r;
    always_ff @(posedge clk) cnt_r <= (rst || !rtsOut) ? 32'h0 : cnt_r + 32'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence sIdleReq; txPending && !rtsOut && !txGo; endsequence
    sequence sTwo; activeSetting == 2'h2 && $past(activeSetting) == 2'h2; endsequence
    AST_P2P: assert property (activeSetting == 2'h0 && $past(activeSetting) == 2'h0 |-> txDrvEn)
        else $error("p2p driver off");
    AST_HALF_RX: assert property (activeSetting == 2'h1 && txGo |-> !rxEn && txDrvEn)
        else $error("half duplex gating");
    AST_TW_DRV: assert property (sTwo |-> txDrvEn == $past(ctsIn))
        else $error("two-wire driver");
    AST_TW_RX: assert property (sTwo |-> rxEn == !txDrvEn)
        else $error("two-wire receiver");
    AST_OPT: assert property (sTwo |-> optionsOut[8:7] == 2'h3)
        else $error("option bits");
    AST_DEF: assert property ((portNum[0] == portNum[1] || protoMode == 2'h0) && !txPending
        && !rtsOut |=> ##1 activeSetting == 2'h0) else $error("setting not p2p");
    AST_RTS: assert property (sIdleReq |=> rtsOut) else $error("rts late");
    AST_GO: assert property ($rose(txGo) |-> rtsOut && $past(ctsIn)) else $error("go early");
    AST_DLY: assert property ($rose(txGo) |-> cnt_r >= ctsDelay * TICK_CYC)
        else $error("delay short");
    AST_WAIT: assert property (rtsOut && !txGo && !ctsIn && !$past(ctsIn) |=> rtsOut && !txGo)
        else $error("wait broken");
    AST_REL: assert property (txLastDone && rtsOut |=> !rtsOut && !txGo) else $error("no release");
    AST_HOLD: assert property (rtsOut && $past(rtsOut) |-> $stable(activeSetting))
        else $error("setting moved");
endmodule
bind sld_line_driver sld_line_asserts #(.TICK_CYC(TICK_CYC)) sld_line_asserts_inst (.*);
`default_nettype wire

// [tb/sld_modem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sld_modem_model (
    input  wire logic       clk,
    input  wire logic       rtsOut,
    input  wire logic [3:0] lag,
    output var  logic       ctsIn = 1'b0
);
    // A lag of 4'hF never grants, so the port is seen waiting with no error.
    logic [3:0] n_r = 4'h0;
    always @(posedge clk) begin
        n_r <= rtsOut ? n_r + {3'h0, n_r != 4'hE} : 4'h0;
        ctsIn <= rtsOut && n_r >= lag && lag != 4'hF;
    end
endmodule
`default_nettype wire

// [tb/tb_sld_line_driver.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_sld_line_driver;
    logic        clk, rst, txPending, txLastDone, ctsIn, rtsOut, txDrvEn, rxEn, txGo;
    logic [1:0]  portNum, protoMode, driverSel, activeSetting;
    logic [15:0] ctsDelay, optionsIn, optionsOut;
    logic [3:0]  lag;
    int          n_fail = 0, checks = 0;
    sld_line_driver #(.TICK_CYC(4)) sld_line_driver_inst (.*);
    sld_modem_model sld_modem_model_inst (.*);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task results;
        $display("checks %0d, failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [15:0] s, e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("Error %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task cfg(input logic [1:0] p, m, s, x);
        {portNum, protoMode, driverSel} = {p, m, s};
        step(4);
        chk(activeSetting, x);
    endtask
    // Tries a setting change mid-message; it must not land until idle.
    task msg(input logic [15:0] d, input logic [1:0] xr, s);
        int i;
        i = 0;
        {ctsDelay, txPending} = {d, 1'b1};
        while (txGo !== 1'b1 && i < 300) begin
            step(1);
            i++;
        end
        if (i == 300) begin
            n_fail++;
            results;
        end
        chk(i >= d * 4, 1'b1);
        step(1);
        chk({txDrvEn, rxEn}, xr);
        driverSel = s ^ 2'h1;
        step(3);
        chk(activeSetting, s);
        {driverSel, txLastDone, txPending} = {s, 2'h2};
        step(1);
        txLastDone = 1'b0;
        chk({rtsOut, txGo}, 2'h0);
        step(2);
    endtask
    initial begin
        {rst, txPending, txLastDone, ctsDelay, optionsIn, lag} = {1'b1, 38'h0};
        {portNum, protoMode, driverSel} = 6'h06;
        step(16);
        rst = 1'b0;
        step(1);
        chk({rtsOut, txGo, txDrvEn, rxEn, activeSetting}, 16'h0C);
        chk(optionsOut, 16'h0000);
        cfg(2'h0, 2'h1, 2'h2, 2'h0);
        cfg(2'h1, 2'h0, 2'h2, 2'h0);
        cfg(2'h1, 2'h1, 2'h1, 2'h1);
        msg(16'h000A, 2'h2, 2'h1);
        cfg(2'h2, 2'h1, 2'h0, 2'h0);
        msg(16'h0000, 2'h3, 2'h0);
        cfg(2'h2, 2'h2, 2'h2, 2'h2);
        chk(optionsOut, 16'h0180);
        chk(txDrvEn, 1'b0);
        {lag, txPending} = {4'hF, 1'b1};
        step(40);
        chk({rtsOut, txGo}, 2'h2);
        lag = 4'h0;
        msg(16'h0000, 2'h2, 2'h2);
        results;
    end
endmodule
`default_nettype wire
